// ==== iop_pkg.sv ====
// iop_pkg: constants, register map and types for the gpio port block.
// assumes an 8-pin port behind a 32-bit apb slave.
package iop_pkg;
  localparam int unsigned IOP_PINS = 8;
  localparam int unsigned IOP_AW = 12;
  // register byte offsets
  localparam logic [11:0] IOP_OFS_OUT = 12'h000;
  localparam logic [11:0] IOP_OFS_PIN = 12'h004;
  localparam logic [11:0] IOP_OFS_DM0 = 12'h008;
  localparam logic [11:0] IOP_OFS_DM1 = 12'h00C;
  localparam logic [11:0] IOP_OFS_DM2 = 12'h010;
  localparam logic [11:0] IOP_OFS_RISE = 12'h014;
  localparam logic [11:0] IOP_OFS_FALL = 12'h018;
  localparam logic [11:0] IOP_OFS_PEND = 12'h01C;
  localparam logic [11:0] IOP_OFS_SEL = 12'h020;
  localparam logic [11:0] IOP_OFS_RCFG = 12'h024;
  localparam logic [11:0] IOP_OFS_LP = 12'h028;
  // per-pin window: 0x100 + 4*pin
  localparam logic [11:0] IOP_OFS_PINWIN = 12'h100;
  // per-pin word fields
  localparam int unsigned IOP_PW_OUT = 0;
  localparam int unsigned IOP_PW_DM = 1;
  localparam int unsigned IOP_PW_RISE = 4;
  localparam int unsigned IOP_PW_FALL = 5;
  localparam int unsigned IOP_PW_SEL = 6;
  localparam int unsigned IOP_PW_PIN = 8;
  localparam int unsigned IOP_PW_PEND = 9;
  // drive modes, three bits per pin, eight choices
  localparam logic [2:0] IOP_DM_HIZ_ANALOG = 3'h0;
  localparam logic [2:0] IOP_DM_HIZ_DIGITAL = 3'h1;
  localparam logic [2:0] IOP_DM_PULL_UP = 3'h2;
  localparam logic [2:0] IOP_DM_PULL_DOWN = 3'h3;
  localparam logic [2:0] IOP_DM_OD_LOW = 3'h4;
  localparam logic [2:0] IOP_DM_OD_HIGH = 3'h5;
  localparam logic [2:0] IOP_DM_STRONG = 3'h6;
  localparam logic [2:0] IOP_DM_STRONG_SLOW = 3'h7;
  // reset-config codes
  localparam logic [1:0] IOP_RC_HIZ = 2'h0;
  localparam logic [1:0] IOP_RC_PULL_DOWN = 2'h1;
  localparam logic [1:0] IOP_RC_PULL_UP = 2'h2;
  localparam logic [31:0] IOP_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {IOP_ST_RESET, IOP_ST_LOAD, IOP_ST_RUN} iop_state_t;
endpackage

// ==== iop_pin_sync.sv ====
// iop_pin_sync: two-flop synchroniser and edge detect for each pin.
// assumes pin levels may change at any time relative to clk_sys_in.
`timescale 1ns/1ps
module iop_pin_sync (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // raw pins
  input wire logic [iop_pkg::IOP_PINS-1:0] pin_in,
  // synced level and edges
  output logic [iop_pkg::IOP_PINS-1:0] level_out,
  output logic [iop_pkg::IOP_PINS-1:0] rise_out,
  output logic [iop_pkg::IOP_PINS-1:0] fall_out
);
  import iop_pkg::*;
  logic [IOP_PINS-1:0] s1_q;
  logic [IOP_PINS-1:0] s2_q;
  logic [IOP_PINS-1:0] s3_q;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q; // [RULE_15]
      s3_q <= s2_q;
    end
  end

  assign level_out = s2_q;
  assign rise_out = s2_q & ~s3_q;
  assign fall_out = ~s2_q & s3_q;
endmodule

// ==== iop_port.sv ====
// iop_port: one 8-pin gpio port with apb registers and port interrupt.
// assumes a single 125 MHz clock; pads resolve level from oe and pull.
// Function
// [RULE_01] each pin works as digital input and output for cpu, dma or fabric.
// [RULE_02] each pin can interrupt on rising, falling or both edges.
// [RULE_03] level interrupts are not detected here, only through the fabric.
// [RULE_04] all pin events of the port merge onto one port interrupt.
// [RULE_05] pin state reads are separate from the output data register.
// [RULE_06] each pin has one of eight drive modes, set up at reset end.
// [RULE_07] one drive mode applies slew-rate control to the output driver.
// [RULE_08] registers are reachable as a whole port or per pin.
// [RULE_09] during reset every pin is high-impedance analog, driver off.
// [RULE_10] after reset a port may default to pull-down or pull-up.
// [RULE_11] the stored reset configuration loads on release automatically.
// [RULE_12] in low power pins keep drive state and value.
// [RULE_13] edge detection keeps working in low power to wake the device.
// [RULE_14] every pin joins the boundary scan chain.
// [RULE_15] inputs are synced before edge detect; pending is sticky.
`timescale 1ns/1ps
module iop_port (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [iop_pkg::IOP_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // nonvolatile reset configuration
  input wire logic [1:0] nv_reset_cfg_in,
  // fabric side
  input wire logic [iop_pkg::IOP_PINS-1:0] fab_out_in,
  output logic [iop_pkg::IOP_PINS-1:0] fab_pin_out,
  // low power and wake
  input wire logic low_power_in,
  output logic wake_out,
  output logic port_irq_out,
  // boundary scan
  input wire logic bsc_mode_in,
  input wire logic bsc_shift_in,
  input wire logic bsc_capture_in,
  input wire logic bsc_update_in,
  input wire logic bsc_tdi_in,
  output logic bsc_tdo_out,
  // pads
  input wire logic [iop_pkg::IOP_PINS-1:0] pad_in,
  output logic [iop_pkg::IOP_PINS-1:0] pad_out,
  output logic [iop_pkg::IOP_PINS-1:0] pad_oe_out,
  output logic [iop_pkg::IOP_PINS-1:0] pad_pu_out,
  output logic [iop_pkg::IOP_PINS-1:0] pad_pd_out,
  output logic [iop_pkg::IOP_PINS-1:0] pad_slow_out,
  output logic [iop_pkg::IOP_PINS-1:0] pad_dig_in_en_out
);
  import iop_pkg::*;

  iop_state_t st_q;
  logic [IOP_PINS-1:0] out_q;
  logic [IOP_PINS-1:0] rise_en_q;
  logic [IOP_PINS-1:0] fall_en_q;
  logic [IOP_PINS-1:0] pend_q;
  logic [IOP_PINS-1:0] sel_q;
  logic [3*IOP_PINS-1:0] dm_q;
  logic [1:0] rcfg_q;
  logic [IOP_PINS-1:0] lvl;
  logic [IOP_PINS-1:0] rise;
  logic [IOP_PINS-1:0] fall;
  logic [IOP_PINS-1:0] hit;
  logic [IOP_PINS-1:0] pend_clr;
  logic [IOP_PINS-1:0] bsc_sh_q;
  logic [IOP_PINS-1:0] bsc_up_q;
  logic [IOP_PINS-1:0] bsc_oe_q;
  logic acc;
  logic wr;
  logic rd;
  logic pinwin;
  logic [2:0] pidx;
  logic mapped;
  logic [31:0] rdata;

  // reset-config code to drive mode
  function automatic logic [2:0] rc_mode(input logic [1:0] rc);
    case (rc)
      IOP_RC_PULL_DOWN: rc_mode = IOP_DM_PULL_DOWN;
      IOP_RC_PULL_UP: rc_mode = IOP_DM_PULL_UP;
      default: rc_mode = IOP_DM_HIZ_ANALOG;
    endcase
  endfunction

  function automatic logic [2:0] dm_of(input logic [3*IOP_PINS-1:0] d,
                                       input int unsigned i);
    dm_of = d[3*i +: 3];
  endfunction

  iop_pin_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .pin_in(pad_in),
    .level_out(lvl),
    .rise_out(rise),
    .fall_out(fall)
  );

  // apb decode, zero wait states
  assign acc = psel_in & penable_in;
  assign wr = acc & pwrite_in;
  assign rd = acc & ~pwrite_in;
  assign pinwin = (paddr_in[11:8] == IOP_OFS_PINWIN[11:8])
                  && (paddr_in[7:5] == 3'h0) && (paddr_in[1:0] == 2'h0);
  assign pidx = paddr_in[4:2];

  // reset sequencing: hold hiz, then copy stored config once
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      st_q <= IOP_ST_RESET;
      rcfg_q <= IOP_RC_HIZ;
    end else begin
      case (st_q)
        IOP_ST_RESET: st_q <= IOP_ST_LOAD;
        IOP_ST_LOAD: begin
          rcfg_q <= nv_reset_cfg_in; // [RULE_11]
          st_q <= IOP_ST_RUN;
        end
        IOP_ST_RUN: begin
          if (wr && paddr_in == IOP_OFS_RCFG)
            rcfg_q <= pwdata_in[1:0];
        end
        default: st_q <= IOP_ST_RESET;
      endcase
    end
  end

  // output data, whole port or per pin
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      out_q <= '0;
    end else if (wr && paddr_in == IOP_OFS_OUT) begin
      out_q <= pwdata_in[IOP_PINS-1:0]; // [RULE_05]
    end else if (wr && pinwin) begin
      out_q[pidx] <= pwdata_in[IOP_PW_OUT]; // [RULE_08]
    end
  end

  // drive modes: hiz analog in reset, stored default at load
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      dm_q <= '0; // [RULE_09]
    end else if (st_q == IOP_ST_LOAD) begin
      dm_q <= {IOP_PINS{rc_mode(nv_reset_cfg_in)}}; // [RULE_06] [RULE_10]
    end else if (wr && paddr_in == IOP_OFS_DM0) begin
      dm_q[7:0] <= pwdata_in[7:0];
    end else if (wr && paddr_in == IOP_OFS_DM1) begin
      dm_q[15:8] <= pwdata_in[7:0];
    end else if (wr && paddr_in == IOP_OFS_DM2) begin
      dm_q[23:16] <= pwdata_in[7:0];
    end else if (wr && pinwin) begin
      dm_q[3*pidx +: 3] <= pwdata_in[IOP_PW_DM +: 3]; // [RULE_08]
    end
  end

  // edge enables and fabric select
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rise_en_q <= '0;
      fall_en_q <= '0;
      sel_q <= '0;
    end else if (wr && paddr_in == IOP_OFS_RISE) begin
      rise_en_q <= pwdata_in[IOP_PINS-1:0];
    end else if (wr && paddr_in == IOP_OFS_FALL) begin
      fall_en_q <= pwdata_in[IOP_PINS-1:0];
    end else if (wr && paddr_in == IOP_OFS_SEL) begin
      sel_q <= pwdata_in[IOP_PINS-1:0];
    end else if (wr && pinwin) begin
      rise_en_q[pidx] <= pwdata_in[IOP_PW_RISE];
      fall_en_q[pidx] <= pwdata_in[IOP_PW_FALL];
      sel_q[pidx] <= pwdata_in[IOP_PW_SEL];
    end
  end

  // edge only; level sense belongs to the fabric path via fab_pin_out
  assign hit = (rise & rise_en_q) | (fall & fall_en_q); // [RULE_02] [RULE_03]

  // clear on write-one or on read; a new edge wins over the clear
  always_comb begin
    pend_clr = '0;
    if (wr && paddr_in == IOP_OFS_PEND)
      pend_clr = pwdata_in[IOP_PINS-1:0];
    else if (rd && paddr_in == IOP_OFS_PEND)
      pend_clr = '1;
    else if (wr && pinwin && pwdata_in[IOP_PW_PEND])
      pend_clr[pidx] = 1'b1;
  end

  // runs regardless of low_power_in so edges still wake the part
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | hit; // [RULE_15] [RULE_13]
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      port_irq_out <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      port_irq_out <= |((pend_q & ~pend_clr) | hit); // [RULE_04]
      wake_out <= low_power_in & (|hit); // [RULE_13]
    end
  end

  // boundary scan: capture pins, shift, update drives
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      bsc_sh_q <= '0;
      bsc_up_q <= '0;
      bsc_oe_q <= '0;
    end else if (bsc_capture_in) begin
      bsc_sh_q <= lvl; // [RULE_14]
    end else if (bsc_shift_in) begin
      bsc_sh_q <= {bsc_tdi_in, bsc_sh_q[IOP_PINS-1:1]};
    end else if (bsc_update_in) begin
      bsc_up_q <= bsc_sh_q;
      bsc_oe_q <= '1;
    end
  end

  // pad drive; low_power_in changes nothing so state is kept
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pad_out <= '0;
      pad_oe_out <= '0; // [RULE_09]
      pad_pu_out <= '0;
      pad_pd_out <= '0;
      pad_slow_out <= '0;
      pad_dig_in_en_out <= '0;
      fab_pin_out <= '0;
      bsc_tdo_out <= 1'b0;
    end else begin
      fab_pin_out <= lvl; // [RULE_01]
      bsc_tdo_out <= bsc_sh_q[0];
      for (int i = 0; i < IOP_PINS; i++) begin
        logic [2:0] m;
        logic v;
        m = dm_of(dm_q, i);
        v = bsc_mode_in ? bsc_up_q[i] : (sel_q[i] ? fab_out_in[i] : out_q[i]);
        pad_out[i] <= v; // [RULE_01] [RULE_12]
        pad_pu_out[i] <= (m == IOP_DM_PULL_UP);
        pad_pd_out[i] <= (m == IOP_DM_PULL_DOWN);
        pad_slow_out[i] <= (m == IOP_DM_STRONG_SLOW); // [RULE_07]
        pad_dig_in_en_out[i] <= (m != IOP_DM_HIZ_ANALOG);
        if (bsc_mode_in)
          pad_oe_out[i] <= bsc_oe_q[i]; // [RULE_14]
        else begin
          case (m)
            IOP_DM_STRONG, IOP_DM_STRONG_SLOW: pad_oe_out[i] <= 1'b1;
            IOP_DM_OD_LOW: pad_oe_out[i] <= ~v;
            IOP_DM_OD_HIGH: pad_oe_out[i] <= v;
            IOP_DM_PULL_UP: pad_oe_out[i] <= ~v;
            IOP_DM_PULL_DOWN: pad_oe_out[i] <= v;
            default: pad_oe_out[i] <= 1'b0;
          endcase
        end
      end
    end
  end

  // read mux
  always_comb begin
    rdata = IOP_ZERO;
    mapped = 1'b1;
    if (pinwin) begin
      rdata[IOP_PW_OUT] = out_q[pidx];
      rdata[IOP_PW_DM +: 3] = dm_q[3*pidx +: 3];
      rdata[IOP_PW_RISE] = rise_en_q[pidx];
      rdata[IOP_PW_FALL] = fall_en_q[pidx];
      rdata[IOP_PW_SEL] = sel_q[pidx];
      rdata[IOP_PW_PIN] = lvl[pidx];
      rdata[IOP_PW_PEND] = pend_q[pidx];
    end else begin
      case (paddr_in)
        IOP_OFS_OUT: rdata[IOP_PINS-1:0] = out_q;
        IOP_OFS_PIN: rdata[IOP_PINS-1:0] = lvl; // [RULE_05]
        IOP_OFS_DM0: rdata[7:0] = dm_q[7:0];
        IOP_OFS_DM1: rdata[7:0] = dm_q[15:8];
        IOP_OFS_DM2: rdata[7:0] = dm_q[23:16];
        IOP_OFS_RISE: rdata[IOP_PINS-1:0] = rise_en_q;
        IOP_OFS_FALL: rdata[IOP_PINS-1:0] = fall_en_q;
        IOP_OFS_PEND: rdata[IOP_PINS-1:0] = pend_q;
        IOP_OFS_SEL: rdata[IOP_PINS-1:0] = sel_q;
        IOP_OFS_RCFG: rdata[1:0] = rcfg_q;
        IOP_OFS_LP: rdata[0] = low_power_in;
        default: mapped = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      prdata_out <= IOP_ZERO;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~mapped;
      prdata_out <= (psel_in & ~penable_in & ~pwrite_in) ? rdata : IOP_ZERO;
    end
  end

  // an edge in the same cycle as a clear must leave the bit set
  a_pend_sticky: assert property ( // [RULE_15]
    @(posedge clk_sys_in) disable iff (reset_in)
    (|hit) |=> (|pend_q)) else $error("edge lost");
  a_rise_pend: assert property ( // [RULE_02]
    @(posedge clk_sys_in) disable iff (reset_in)
    (rise[0] && rise_en_q[0]) |=> pend_q[0]) else $error("rise missed");
  a_irq_merge: assert property ( // [RULE_04]
    @(posedge clk_sys_in) disable iff (reset_in)
    (|pend_q) && !(|pend_clr) |=> port_irq_out) else $error("irq low");
  a_load_cfg: assert property ( // [RULE_11]
    @(posedge clk_sys_in) disable iff (reset_in)
    (st_q == IOP_ST_LOAD) |=> (rcfg_q == $past(nv_reset_cfg_in)))
    else $error("cfg not loaded");
  a_pin_read: assert property ( // [RULE_05]
    @(posedge clk_sys_in) disable iff (reset_in)
    (psel_in && !penable_in && !pwrite_in && paddr_in == IOP_OFS_PIN)
    |=> (prdata_out[IOP_PINS-1:0] == $past(lvl))) else $error("pin read");
  a_slow_mode: assert property ( // [RULE_07]
    @(posedge clk_sys_in) disable iff (reset_in)
    (dm_q[2:0] == IOP_DM_STRONG_SLOW) |=> pad_slow_out[0])
    else $error("slew off");
  a_out_hold: assert property ( // [RULE_12]
    @(posedge clk_sys_in) disable iff (reset_in)
    low_power_in && !wr |=> $stable(out_q)) else $error("state lost");
  a_wake_edge: assert property ( // [RULE_13]
    @(posedge clk_sys_in) disable iff (reset_in)
    (low_power_in && (|hit)) |=> wake_out) else $error("no wake");
  a_hiz_start: assert property ( // [RULE_09]
    @(posedge clk_sys_in) disable iff (reset_in)
    (st_q != IOP_ST_RUN) |-> (pad_oe_out == '0)) else $error("driven");
  a_scan_drive: assert property ( // [RULE_14]
    @(posedge clk_sys_in) disable iff (reset_in)
    bsc_mode_in |=> (pad_out == $past(bsc_up_q))) else $error("scan drive");
  a_set_wins: assert property ( // [RULE_15]
    @(posedge clk_sys_in) disable iff (reset_in)
    (hit[0] && pend_clr[0]) |=> pend_q[0]) else $error("clear beat edge");
  c_irq: cover property (@(posedge clk_sys_in) port_irq_out);
  c_pinwin_wr: cover property (@(posedge clk_sys_in) wr && pinwin);
  c_wake: cover property (@(posedge clk_sys_in) wake_out);
  c_scan: cover property (@(posedge clk_sys_in) bsc_mode_in && bsc_oe_q[0]);
endmodule

// ==== iop_board.sv ====
// iop_board: board circuitry on the far side of the port pads.
// assumes pads resolve from design oe, pulls and an external driver.
`timescale 1ns/1ps
module iop_board (
  // clock
  input wire logic clk_in,
  // design pad controls
  input wire logic [7:0] pad_out_in,
  input wire logic [7:0] oe_in,
  input wire logic [7:0] pu_in,
  input wire logic [7:0] pd_in,
  // external driver
  input wire logic [7:0] ext_en_in,
  input wire logic [7:0] ext_val_in,
  // resolved level
  output logic [7:0] pad_level_out
);
  logic [7:0] float_q;

  // a floating pin flips every cycle so no stale value reads as valid
  always_ff @(posedge clk_in) begin
    float_q <= ~pad_level_out;
  end

  // external source is resistive: the device driver wins a contention
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_in[i]) pad_level_out[i] = pad_out_in[i];
      else if (ext_en_in[i]) pad_level_out[i] = ext_val_in[i];
      else if (pu_in[i]) pad_level_out[i] = 1'b1;
      else if (pd_in[i]) pad_level_out[i] = 1'b0;
      else pad_level_out[i] = float_q[i];
    end
  end
endmodule

// ==== tb.sv ====
// tb: self-checking bench for the gpio port, apb master and board model.
// assumes the port answers apb in one access phase as the design states.
`timescale 1ns/1ps
module tb;
  import iop_pkg::*;
  logic clk_sys_in, reset_in, psel_in, penable_in, pwrite_in, pready_out;
  logic pslverr_out, low_power_in, wake_out, port_irq_out, err;
  logic [1:0] nv_reset_cfg_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [7:0] fab_out_in, fab_pin_out, pad_in, pad_out, pad_oe_out;
  logic [7:0] pad_pu_out, pad_pd_out, pad_slow_out, ext_en, ext_val, v, w;
  logic [7:0] oe_ref;
  logic bsc_mode, bsc_shift, bsc_capture, bsc_update, bsc_tdi, bsc_tdo;
  logic [7:0] dig_en, tdo_hist;
  int bad_count, n_tests, seed, p, m, k, j, wake_cnt;

  // scan chain driven by the bench
  iop_port uut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .nv_reset_cfg_in(nv_reset_cfg_in), .fab_out_in(fab_out_in),
    .fab_pin_out(fab_pin_out), .low_power_in(low_power_in),
    .wake_out(wake_out), .port_irq_out(port_irq_out),
    .bsc_mode_in(bsc_mode), .bsc_shift_in(bsc_shift),
    .bsc_capture_in(bsc_capture), .bsc_update_in(bsc_update),
    .bsc_tdi_in(bsc_tdi), .bsc_tdo_out(bsc_tdo),
    .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe_out(pad_oe_out), .pad_pu_out(pad_pu_out),
    .pad_pd_out(pad_pd_out), .pad_slow_out(pad_slow_out),
    .pad_dig_in_en_out(dig_en));
  iop_board board (.clk_in(clk_sys_in), .pad_out_in(pad_out),
    .oe_in(pad_oe_out), .pu_in(pad_pu_out), .pd_in(pad_pd_out),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .pad_level_out(pad_in));

  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  always @(posedge clk_sys_in) begin
    if (wake_out === 1'b1) wake_cnt++;
  end

  // record of the scan output, newest bit on top
  always @(posedge clk_sys_in) begin
    tdo_hist <= {bsc_tdo, tdo_hist[7:1]};
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wrap_up;
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready_out !== 1'b1 && n < 50);
    if (n >= 50) chk(32'(pready_out), 32'h1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  function logic [11:0] pw(input int q);
    return IOP_OFS_PINWIN + 12'(4 * q);
  endfunction

  function logic [31:0] word(input logic [2:0] mo, input logic o, r, f, s);
    return 32'({s, f, r, mo, o});
  endfunction

  function logic exp_oe(input logic [2:0] mo, input logic o);
    case (mo)
      IOP_DM_OD_LOW: return !o;
      IOP_DM_OD_HIGH: return o;
      IOP_DM_STRONG, IOP_DM_STRONG_SLOW: return 1'b1;
      IOP_DM_PULL_UP: return !o;
      IOP_DM_PULL_DOWN: return o;
      default: return 1'b0;
    endcase
  endfunction

  task do_reset(input logic [1:0] cfg);
    @(posedge clk_sys_in);
    nv_reset_cfg_in <= cfg;
    reset_in <= 1'b1;
    repeat (20) @(posedge clk_sys_in);
    chk(32'(pad_oe_out), 32'h0);
    chk(32'({pad_pu_out, pad_pd_out, pad_slow_out}), 32'h0);
    chk(32'(dig_en), 32'h0);
    reset_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    chk(32'(pad_pu_out), {24'h0, {8{cfg == IOP_RC_PULL_UP}}});
    chk(32'(pad_pd_out), {24'h0, {8{cfg == IOP_RC_PULL_DOWN}}});
    apb(1'b0, IOP_OFS_RCFG, 32'h0);
    chk(rd, 32'(cfg));
  endtask

  task edge_wait(input int q, input logic val);
    ext_val[q] <= val;
    repeat (8) @(posedge clk_sys_in);
  endtask

  initial begin
    {reset_in, psel_in, penable_in, pwrite_in, low_power_in} = 5'h10;
    {paddr_in, pwdata_in, fab_out_in} = '0;
    {bsc_mode, bsc_shift, bsc_capture, bsc_update, bsc_tdi} = 5'h00;
    nv_reset_cfg_in = IOP_RC_PULL_UP;
    ext_en = 8'hFF;
    ext_val = 8'h00;
    seed = 17;
    do_reset(IOP_RC_PULL_UP);
    // every drive mode on a random pin, others must stay put
    for (m = 0; m < 8; m++) begin
      p = $unsigned($random(seed)) % 8;
      v = 8'($random(seed));
      oe_ref = pad_oe_out;
      apb(1'b1, pw(p), word(3'(m), v[0], 1'b0, 1'b0, 1'b0));
      apb(1'b0, pw(p), 32'h0);
      chk(rd & 32'hF, word(3'(m), v[0], 1'b0, 1'b0, 1'b0));
      chk(32'(pad_oe_out[p]), 32'(exp_oe(3'(m), v[0])));
      chk(32'({pad_pu_out[p], pad_pd_out[p]}),
          32'({m == IOP_DM_PULL_UP, m == IOP_DM_PULL_DOWN}));
      chk(32'(dig_en[p]), 32'(m != IOP_DM_HIZ_ANALOG));
      if (exp_oe(3'(m), v[0])) chk(32'(pad_out[p]), 32'(v[0]));
      chk(32'(pad_slow_out[p]), 32'(m == 7));
      oe_ref[p] = pad_oe_out[p];
      chk(32'(pad_oe_out), 32'(oe_ref));
    end
    do_reset(IOP_RC_PULL_DOWN);
    // pin state read apart from output data
    for (p = 0; p < 8; p++) begin
      apb(1'b1, pw(p), word(IOP_DM_HIZ_DIGITAL, 1'b0, 1'b0, 1'b0, 1'b0));
    end
    v = 8'($random(seed));
    w = 8'($random(seed));
    ext_val <= w;
    apb(1'b1, IOP_OFS_OUT, 32'(v));
    apb(1'b0, IOP_OFS_PIN, 32'h0);
    chk(rd, 32'(w));
    apb(1'b0, IOP_OFS_OUT, 32'h0);
    chk(rd, 32'(v));
    chk(32'(fab_pin_out), 32'(w));
    // rising, falling and both-edge triggers
    for (k = 0; k < 3; k++) begin
      p = $unsigned($random(seed)) % 8;
      edge_wait(p, 1'b0);
      apb(1'b0, IOP_OFS_PEND, 32'h0);
      apb(1'b1, pw(p), word(IOP_DM_HIZ_DIGITAL, 1'b0, k != 1, k != 0, 1'b0));
      edge_wait(p, 1'b1);
      chk(32'(port_irq_out), 32'(k != 1));
      apb(1'b0, IOP_OFS_PEND, 32'h0);
      chk(rd, 32'(k != 1) << p);
      edge_wait(p, 1'b0);
      chk(32'(port_irq_out), 32'(k != 0));
      apb(1'b1, IOP_OFS_PEND, 32'hFF);
      repeat (2) @(posedge clk_sys_in);
      chk(32'(port_irq_out), 32'h0);
      apb(1'b1, pw(p), word(IOP_DM_HIZ_DIGITAL, 1'b0, 1'b0, 1'b0, 1'b0));
    end
    // low power: drive held, edge wakes
    // pin 1 may still sit high from the random pattern: no edge otherwise
    edge_wait(1, 1'b0);
    apb(1'b1, pw(0), word(IOP_DM_STRONG, 1'b1, 1'b0, 1'b0, 1'b0));
    apb(1'b1, pw(1), word(IOP_DM_HIZ_DIGITAL, 1'b0, 1'b1, 1'b0, 1'b0));
    k = wake_cnt;
    low_power_in <= 1'b1;
    apb(1'b0, IOP_OFS_LP, 32'h0);
    chk(rd, 32'h1);
    edge_wait(1, 1'b1);
    chk(32'(wake_cnt - k), 32'h1);
    chk(32'({pad_oe_out[0], pad_out[0]}), 32'h3);
    low_power_in <= 1'b0;
    // fabric drives a pin and sees it back
    apb(1'b1, pw(2), word(IOP_DM_STRONG, 1'b0, 1'b0, 1'b0, 1'b1));
    v = 8'($random(seed));
    fab_out_in <= v;
    repeat (6) @(posedge clk_sys_in);
    chk(32'(pad_out[2]), 32'(v[2]));
    chk(32'(fab_pin_out[2]), 32'(v[2]));
    // scan: capture pin levels, shift a word in, drive it out
    w = pad_in;
    v = 8'($random(seed));
    bsc_capture <= 1'b1;
    @(posedge clk_sys_in);
    bsc_capture <= 1'b0;
    bsc_shift <= 1'b1;
    for (j = 0; j < 8; j++) begin
      bsc_tdi <= v[j];
      @(posedge clk_sys_in);
    end
    bsc_shift <= 1'b0;
    bsc_update <= 1'b1;
    @(posedge clk_sys_in);
    bsc_update <= 1'b0;
    bsc_mode <= 1'b1;
    @(posedge clk_sys_in);
    chk(32'(tdo_hist), 32'(w));
    repeat (2) @(posedge clk_sys_in);
    chk(32'({pad_oe_out, pad_out}), {16'h0, 8'hFF, v});
    bsc_mode <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    // unmapped word and a window slot past the last pin
    apb(1'b0, 12'h0FC, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, pw(8), 32'hFFFF);
    chk({31'h0, err}, 32'h1);
    wrap_up;
  end

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    bad_count++;
    wrap_up;
  end
endmodule
